// file: design/acsr_top.sv
// channel selection, sequencing and result registers behind an axi4-lite slave
// Summary of operation
// - four select bits choose conversion channels
// - multi mode ignores low select bits
// - group of four, fixed result registers
// - codes route pins, references, reserved
// - half reference by capacitor arrangement
// - four read-only eight-bit results
// - flag set when all four valid
// - results update outside bus read
// - sampling switch closed twelve cycles
// - control write clears flag, restarts
// - scan off once, on round-robin
// - single mode converts one channel four times
// - flag reset cleared, bit6 reads zero
`timescale 1ns/100ps
module acsr_top (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_in,
    output logic [3:0] mux_sel,
    output logic mux_half_ref,
    output logic sample_switch,
    output logic irq
);
    acsr_conv_if cv ();

    logic [5:0] ctrl;
    logic conversions_complete_flag;
    logic [7:0] res [4];
    logic [1:0] slot;
    logic running;
    logic seq_done_pulse;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] div;
    logic tick;
    logic aw_held, w_held;
    logic [5:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic ctrl_wr;
    logic rd_busy;

    wire logic multi_channel_mode = ctrl[acsr_pkg::CTRL_MULTI_CHANNEL_MODE_BIT];
    wire logic scan_mode = ctrl[acsr_pkg::CTRL_SCAN_BIT];
    wire logic [3:0] chan_sel = ctrl[3:0];

    // converter clock enable from divider
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            div <= 2'h0;
            tick <= 1'b0;
        end else begin
            div <= (div == 2'(acsr_pkg::CLK_DIV - 1)) ? 2'h0 : div + 2'h1;
            tick <= (div == 2'h0);
        end
    end

    // write channel: address and data taken in any order
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 6'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= acsr_pkg::RESP_OKAY;
            ctrl_wr <= 1'b0;
        end else begin
            ctrl_wr <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == acsr_pkg::ADDR_CTRL_W || aw_addr == acsr_pkg::ADDR_IRQ_STAT ||
                                aw_addr == acsr_pkg::ADDR_IRQ_MASK) ? acsr_pkg::RESP_OKAY : acsr_pkg::RESP_SLVERR;
                ctrl_wr <= (aw_addr == acsr_pkg::ADDR_CTRL_W) && w_strb[0];
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire logic wr_commit = aw_held && w_held && !s_axi_bvalid;

    // control bits have no reset and keep their value across it
    always_ff @(posedge clk_sys) begin
        if (wr_commit && w_strb[0] && aw_addr == acsr_pkg::ADDR_CTRL_W) begin
            ctrl <= w_data[5:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_mask <= 2'h0;
        end else if (wr_commit && w_strb[0] && aw_addr == acsr_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= w_data[1:0];
        end
    end

    // low bits replaced by slot in multi mode
    // single mode uses all four bits
    // codes pass straight to the analog mux
    // half reference via capacitor arrangement, no divider
    logic [3:0] next_sel;
    logic next_half;
    always_comb begin
        next_sel = multi_channel_mode ? {chan_sel[3:2], ctrl_wr ? 2'h0 : slot + 2'h1} : chan_sel;
        next_half = (next_sel == acsr_pkg::SEL_VHALF);
    end

    // sequencer: ctrl_wr aborts and restarts
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            running <= 1'b0;
            slot <= 2'h0;
            cv.start <= 1'b0;
            cv.sel <= 4'h0;
            cv.half_ref <= 1'b0;
            seq_done_pulse <= 1'b0;
        end else begin
            cv.start <= 1'b0;
            seq_done_pulse <= 1'b0;
            if (ctrl_wr) begin
                running <= 1'b1;
                slot <= 2'h0;
                cv.start <= 1'b1;
                cv.sel <= next_sel;
                cv.half_ref <= next_half;
            end else if (running && cv.done) begin
                slot <= slot + 2'h1;
                if (slot == 2'h3) begin
                    seq_done_pulse <= 1'b1;
                    running <= scan_mode;
                end
                if (slot != 2'h3 || scan_mode) begin
                    cv.start <= 1'b1;
                    cv.sel <= next_sel;
                    cv.half_ref <= next_half;
                end
            end
        end
    end

    acsr_conv_core u_core (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(tick),
        .abort(ctrl_wr),
        .cmp_in(cmp_in),
        .cv(cv)
    );

    // results load only while no read data is being formed
    // slot picks the result register; conversion order
    // reserved codes fill registers all the same
    logic pend;
    logic [1:0] pend_slot;
    logic [7:0] pend_val;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pend <= 1'b0;
            pend_slot <= 2'h0;
            pend_val <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                res[i] <= 8'h00;
            end
        end else begin
            if (running && cv.done && !ctrl_wr) begin
                pend <= 1'b1;
                pend_slot <= slot;
                pend_val <= cv.result;
            end else if (pend && !(s_axi_arvalid && s_axi_arready)) begin
                pend <= 1'b0;
                res[pend_slot] <= pend_val;
            end
        end
    end

    // flag after fourth result lands; cleared by reset
    logic flag_arm;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            conversions_complete_flag <= 1'b0;
            flag_arm <= 1'b0;
        end else if (ctrl_wr) begin
            conversions_complete_flag <= 1'b0;
            flag_arm <= 1'b0;
        end else begin
            if (seq_done_pulse) begin
                flag_arm <= 1'b1;
            end
            if (flag_arm && !pend) begin
                conversions_complete_flag <= 1'b1;
                flag_arm <= 1'b0;
            end
        end
    end

    // sticky events: bit0 sequence complete, bit1 each result; set beats clear
    wire logic [1:0] ev = {pend && !(s_axi_arvalid && s_axi_arready), flag_arm && !pend};
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end else begin
            if (wr_commit && w_strb[0] && aw_addr == acsr_pkg::ADDR_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~w_data[1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // read channel: results read only; bit 6 zero
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= acsr_pkg::RESP_OKAY;
            rd_busy <= 1'b0;
        end else begin
            s_axi_arready <= !rd_busy && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                rd_busy <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= acsr_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    acsr_pkg::ADDR_CTRL_W: s_axi_rdata <= {24'h0, conversions_complete_flag, 1'b0, ctrl[5:0]};
                    acsr_pkg::ADDR_RES1: s_axi_rdata <= {24'h0, res[0]};
                    acsr_pkg::ADDR_RES2: s_axi_rdata <= {24'h0, res[1]};
                    acsr_pkg::ADDR_RES3: s_axi_rdata <= {24'h0, res[2]};
                    acsr_pkg::ADDR_RES4: s_axi_rdata <= {24'h0, res[3]};
                    acsr_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
                    acsr_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= acsr_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rd_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mux_sel <= 4'h0;
            mux_half_ref <= 1'b0;
            sample_switch <= 1'b0;
        end else begin
            mux_sel <= cv.sel;
            mux_half_ref <= cv.half_ref;
            sample_switch <= cv.sample_sw;
        end
    end

    // sample switch stays closed at most twelve converter ticks, exactly twelve unless a control write aborts
    logic [5:0] sw_ticks;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sw_ticks <= 6'h00;
        end else if (!cv.sample_sw) begin
            sw_ticks <= 6'h00;
        end else if (tick) begin
            sw_ticks <= sw_ticks + 6'h01;
        end
    end

    sample_len_a: assert property (@(posedge clk_sys) disable iff (reset)
        sw_ticks <= 6'd12) else $error("sample window too long");
    sample_full_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(cv.sample_sw) && !$past(ctrl_wr) |-> sw_ticks == 6'd12) else $error("sample cut short");
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        ctrl_wr |=> !conversions_complete_flag) else $error("flag not cleared by write");
    restart_a: assert property (@(posedge clk_sys) disable iff (reset)
        ctrl_wr |=> cv.start && running) else $error("no restart after write");
    multi_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cv.start) && multi_channel_mode && !ctrl_wr && !$past(ctrl_wr) |-> cv.sel[1:0] == slot)
        else $error("multi mode channel wrong");
    single_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
        cv.start && !multi_channel_mode && !ctrl_wr |-> cv.sel == chan_sel) else $error("sel wrong");
    half_ref_a: assert property (@(posedge clk_sys) disable iff (reset)
        cv.start |-> cv.half_ref == (cv.sel == acsr_pkg::SEL_VHALF)) else $error("half ref mismatch");
    no_rd_upd_a: assert property (@(posedge clk_sys) disable iff (reset)
        (s_axi_arvalid && s_axi_arready) |=> $stable(res[0]) && $stable(res[1]) && $stable(res[2]) && $stable(res[3]))
        else $error("result changed during read");
    bit6_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        s_axi_rvalid && $past(s_axi_araddr) == 6'h00 && $rose(s_axi_rvalid) |-> !s_axi_rdata[6])
        else $error("bit 6 not zero");
    once_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
        seq_done_pulse && !scan_mode && !ctrl_wr |=> !running) else $error("single pass kept running");
    flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(conversions_complete_flag) |-> $past(flag_arm) && !$past(pend)) else $error("flag set early");
endmodule

// file: design/acsr_pkg.sv
// constants for the converter channel-select and result logic
package acsr_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [5:0] ADDR_RES1 = 6'h04;
    localparam logic [5:0] ADDR_RES2 = 6'h08;
    localparam logic [5:0] ADDR_RES3 = 6'h0c;
    localparam logic [5:0] ADDR_RES4 = 6'h10;
    localparam logic [5:0] ADDR_RES_BASE = 6'h04;
    localparam logic [5:0] ADDR_IRQ_STAT = 6'h14;
    localparam logic [5:0] ADDR_IRQ_MASK = 6'h18;
    localparam logic [5:0] ADDR_CTRL_W = 6'h00;
    localparam int CTRL_FLAG_BIT = 7;
    localparam int CTRL_ZERO_BIT = 6;
    localparam int CTRL_SCAN_BIT = 5;
    localparam int CTRL_MULTI_CHANNEL_MODE_BIT = 4;
    localparam logic [3:0] SEL_PIN_MAX = 4'h7;
    localparam logic [3:0] SEL_VHIGH = 4'hc;
    localparam logic [3:0] SEL_VLOW = 4'hd;
    localparam logic [3:0] SEL_VHALF = 4'he;
    localparam int unsigned SAMPLE_CYCLES = 12;
    localparam int unsigned CONV_CYCLES = 32;
    localparam int unsigned CLK_DIV = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: design/acsr_conv_if.sv
// handshake between the sequencer and the converter core
`timescale 1ns/100ps
interface acsr_conv_if;
    logic start;
    logic [3:0] sel;
    logic half_ref;
    logic sample_sw;
    logic done;
    logic [7:0] result;
    modport seq (output start, output sel, output half_ref, input sample_sw, input done, input result);
    modport core (input start, input sel, input half_ref, output sample_sw, output done, output result);
endinterface

// file: design/acsr_conv_core.sv
// successive-approximation core: sample window then one bit per tick
`timescale 1ns/100ps
module acsr_conv_core #(
    parameter int unsigned SAMPLE = acsr_pkg::SAMPLE_CYCLES,
    parameter int unsigned TOTAL = acsr_pkg::CONV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic tick,
    input wire logic abort,
    input wire logic cmp_in,
    acsr_conv_if.core cv
);
    logic [5:0] cnt;
    logic busy;
    logic [7:0] sar;
    logic [2:0] bitpos;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            cnt <= 6'h00;
            cv.sample_sw <= 1'b0;
            cv.done <= 1'b0;
        end else begin
            cv.done <= 1'b0;
            if (abort || cv.start) begin
                busy <= cv.start;
                cnt <= 6'h00;
                cv.sample_sw <= 1'b0;
            end else if (busy && tick) begin
                cnt <= cnt + 6'h01;
                // closes on a tick so the window is whole ticks
                if (cnt == 6'h00) begin
                    cv.sample_sw <= 1'b1;
                end
                if (cnt == 6'(SAMPLE)) begin
                    cv.sample_sw <= 1'b0;
                end
                if (cnt == 6'(TOTAL - 1)) begin
                    busy <= 1'b0;
                    cv.done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sar <= 8'h00;
            bitpos <= 3'h7;
            cv.result <= 8'h00;
        end else if (cv.start) begin
            sar <= 8'h80;
            bitpos <= 3'h7;
        end else if (busy && tick && cnt >= 6'(SAMPLE) && cnt < 6'(SAMPLE + 8)) begin
            // comparator high means keep the trial bit
            if (!cmp_in) begin
                sar[bitpos] <= 1'b0;
            end
            if (bitpos != 3'h0) begin
                sar[bitpos - 3'h1] <= 1'b1;
                bitpos <= bitpos - 3'h1;
            end
        end else if (busy && tick && cnt == 6'(TOTAL - 1)) begin
            cv.result <= sar;
        end
    end
endmodule

// file: verification/acsr_analog_src.sv
// analog source model: a fixed level on every channel, seen through the comparator
`timescale 1ns/100ps
module acsr_analog_src (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] mux_sel,
    input wire logic sample_switch,
    input wire logic invert,
    output logic cmp_in
);
    // full scale or ground per channel, so each result is ff or 00
    localparam logic [15:0] LEVELS = 16'h1a53;
    logic held;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            held <= 1'b0;
        end else if (sample_switch) begin
            held <= LEVELS[mux_sel] ^ invert;
        end
    end
    assign cmp_in = held;
endmodule

// file: verification/tb_adc_channel_select_results.sv
// self-checking bench: register sequences over axi4-lite against the source model
`timescale 1ns/100ps
module tb_adc_channel_select_results;
    localparam logic [15:0] LEVELS = 16'h1a53;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic invert = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cmp_in, mux_half_ref, sample_switch, irq;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata, rd;
    logic [3:0] mux_sel;
    logic [3:0] seen_sel[$];
    logic seen_half[$];
    logic sw_q = 1'b0;
    int win_len = 0;
    int last_len = 0;
    int n_errors = 0;
    int cmp_count = 0;
    logic [7:0] codes[8] = '{8'h0d, 8'h0b, 8'h0e, 8'h0c, 8'h13, 8'h16, 8'h19, 8'h1f};

    always #2 clk_sys = ~clk_sys;

    acsr_top dut_u (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .cmp_in(cmp_in),
        .mux_sel(mux_sel), .mux_half_ref(mux_half_ref), .sample_switch(sample_switch), .irq(irq));
    acsr_analog_src src_u (.clk_sys(clk_sys), .reset(reset), .mux_sel(mux_sel),
        .sample_switch(sample_switch), .invert(invert), .cmp_in(cmp_in));

    // channel is captured in the fifth cycle of the window, clear of any edge where the mux may move
    always @(posedge clk_sys) begin
        sw_q <= sample_switch;
        if (sample_switch) begin
            win_len <= win_len + 1;
            if (win_len == 4) begin
                seen_sel.push_back(mux_sel);
                seen_half.push_back(mux_half_ref);
            end
        end else begin
            win_len <= 0;
            if (sw_q) last_len <= win_len;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        last_resp = bresp;
        if (n == 200) check(32'h0, 32'h1, "write hang");
    endtask

    task automatic rd_reg(input logic [5:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        last_resp = rresp;
        if (n == 200) check(32'h0, 32'h1, "read hang");
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 400; k++) begin
            rd_reg(acsr_pkg::ADDR_CTRL_W);
            if (rd[acsr_pkg::CTRL_FLAG_BIT] === 1'b1) break;
        end
        if (k == 400) check(32'h0, 32'h1, "no completion");
    endtask

    function automatic logic [3:0] chan(input logic [7:0] c, input int k);
        return c[acsr_pkg::CTRL_MULTI_CHANNEL_MODE_BIT] ? {c[3:2], 2'(k)} : c[3:0];
    endfunction

    // reserved and half-reference results carry no fixed value here
    task automatic run_seq(input logic [7:0] c);
        int k;
        logic [3:0] ch;
        wr(acsr_pkg::ADDR_CTRL_W, {24'h0, c});
        seen_sel.delete();
        seen_half.delete();
        check({30'h0, last_resp}, {30'h0, acsr_pkg::RESP_OKAY}, "ctrl write resp");
        rd_reg(acsr_pkg::ADDR_CTRL_W);
        check(rd, {26'h0, c[5:0]}, "ctrl readback");
        wait_done();
        for (k = 0; k < 4; k++) begin
            ch = chan(c, k);
            rd_reg(acsr_pkg::ADDR_RES_BASE + 6'(4 * k));
            if (ch[3:2] != 2'b10 && ch != 4'hf && ch != acsr_pkg::SEL_VHALF)
                check(rd, {24'h0, {8{LEVELS[ch] ^ invert}}}, "result value");
            check({28'h0, seen_sel[k]}, {28'h0, ch}, "sampled channel");
            check({31'h0, seen_half[k]}, {31'h0, ch == acsr_pkg::SEL_VHALF}, "half ref");
        end
        check(32'(last_len), 32'(acsr_pkg::SAMPLE_CYCLES * acsr_pkg::CLK_DIV), "sample window");
        if (!c[acsr_pkg::CTRL_SCAN_BIT]) begin
            repeat (300) @(posedge clk_sys);
            check(32'(seen_sel.size()), 32'd4, "single pass count");
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        int k;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd_reg(acsr_pkg::ADDR_CTRL_W);
        // control bits are unknown until written; only the flag and bit 6 are defined
        check(rd & 32'hffffffc0, 32'h0, "flag and bit 6 after reset");
        wr(acsr_pkg::ADDR_IRQ_MASK, 32'h1);
        run_seq(8'h40);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        rd_reg(acsr_pkg::ADDR_IRQ_STAT);
        check({30'h0, rd[1:0]}, 32'h3, "irq status set");
        wr(acsr_pkg::ADDR_IRQ_STAT, 32'h3);
        rd_reg(acsr_pkg::ADDR_IRQ_STAT);
        check(rd, 32'h0, "irq status cleared");
        check({31'h0, irq}, 32'h0, "irq cleared");
        wr(acsr_pkg::ADDR_IRQ_MASK, 32'h0);
        for (k = 0; k < 8; k++) run_seq(codes[k]);
        check({31'h0, irq}, 32'h0, "irq masked");
        wr(acsr_pkg::ADDR_IRQ_MASK, 32'h1);
        rd_reg(acsr_pkg::ADDR_IRQ_STAT);
        check({31'h0, irq}, 32'h1, "irq on unmask");
        wr(acsr_pkg::ADDR_IRQ_STAT, 32'h3);
        wr(acsr_pkg::ADDR_RES_BASE, 32'h5a);
        check({30'h0, last_resp}, {30'h0, acsr_pkg::RESP_SLVERR}, "result write refused");
        rd_reg(acsr_pkg::ADDR_RES_BASE);
        check(rd, 32'hff, "result unchanged");
        rd_reg(6'h1c);
        check({rd[29:0], last_resp}, {30'h0, acsr_pkg::RESP_SLVERR}, "unmapped read");
        run_seq(8'h34);
        invert <= 1'b1;
        repeat (1200) @(posedge clk_sys);
        rd_reg(acsr_pkg::ADDR_CTRL_W);
        check({31'h0, rd[7]}, 32'h1, "flag held in scan");
        for (k = 0; k < 4; k++) begin
            rd_reg(acsr_pkg::ADDR_RES_BASE + 6'(4 * k));
            check(rd, {24'h0, {8{~LEVELS[4 + k]}}}, "scan update");
        end
        run_seq(8'h00);
        wr(acsr_pkg::ADDR_CTRL_W, 32'h30);
        repeat (200) @(posedge clk_sys);
        reset <= 1'b1;
        repeat (16) @(posedge clk_sys);
        check({25'h0, mux_sel, mux_half_ref, sample_switch, irq}, 32'h0, "outputs in reset");
        reset <= 1'b0;
        @(posedge clk_sys);
        seen_sel.delete();
        rd_reg(acsr_pkg::ADDR_CTRL_W);
        // the flag clears but the written control bits survive reset
        check(rd, 32'h30, "ctrl kept over reset");
        repeat (300) @(posedge clk_sys);
        check(32'(seen_sel.size()), 32'd0, "idle until written");
        final_report();
    end
endmodule
